// File: dio_pkg.sv
// Purpose: shared constants and types of the 32-channel edge monitor port
// Assumes: one clock; all user-side controls come from logic on that clock
// Notes:   the entry type carries one level pattern and its time stamp
package dio_pkg;
    localparam int CHANNELS   = 32;
    localparam int GROUP_SIZE = 8;
    localparam int GROUPS     = CHANNELS / GROUP_SIZE;
    localparam int FIFO_DEPTH = 511;
    localparam int STAMP_W    = 32;
    localparam int FILT_W     = 8;
    localparam int DIV_W      = 8;

    // clock rate and the documented edge sample rate
    localparam longint CLOCK_HZ   = 25_000_000;
    localparam longint SAMPLE_HZ  = 100_000_000;
    // clock cycles per sample; a slower clock samples on every edge
    localparam int     SAMPLE_DIV = (CLOCK_HZ >= SAMPLE_HZ) ?
                                    int'(CLOCK_HZ / SAMPLE_HZ) : 1;

    // uses of the shared fifo
    localparam logic MODE_RECORD = 1'b0;
    localparam logic MODE_OUTPUT = 1'b1;

    // reset values and unit steps
    localparam logic [CHANNELS-1:0] CH_LOW     = 32'h0000_0000;
    localparam logic [STAMP_W-1:0]  STAMP_ZERO = 32'h0000_0000;
    localparam logic [FILT_W-1:0]   FILT_ZERO  = 8'h00;
    localparam logic [FILT_W-1:0]   FILT_ONE   = 8'h01;
    localparam logic [DIV_W-1:0]    DIV_ZERO   = 8'h00;
    localparam logic [DIV_W-1:0]    DIV_ONE    = 8'h01;

    typedef struct packed {
        logic [CHANNELS-1:0] pattern;
        logic [STAMP_W-1:0]  stamp;
    } dio_entry_type;
endpackage

// File: dio_skid.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: flush is a one-cycle pulse on the same clock
// Notes:   out_valid and out_data come straight from flip-flops
`timescale 1ns/1ps
module dio_skid (
    input  wire logic                   clock,
    input  wire logic                   reset,
    input  wire logic                   flush,
    input  wire logic                   in_valid,
    output logic                        in_ready,
    input  wire dio_pkg::dio_entry_type in_data,
    output logic                        out_valid,
    input  wire logic                   out_ready,
    output dio_pkg::dio_entry_type      out_data
);
    dio_pkg::dio_entry_type e0_q;
    dio_pkg::dio_entry_type e0_d;
    dio_pkg::dio_entry_type e1_q;
    dio_pkg::dio_entry_type e1_d;
    logic                   v0_q;
    logic                   v0_d;
    logic                   v1_q;
    logic                   v1_d;
    logic                   pop;
    logic                   push;

    assign in_ready  = ~v1_q;
    assign out_valid = v0_q;
    assign out_data  = e0_q;
    assign pop       = v0_q & out_ready;
    assign push      = in_valid & ~v1_q;

    // head shifts forward on a pop, a push fills the first free slot
    always_comb begin
        e0_d = e0_q;
        e1_d = e1_q;
        v0_d = v0_q;
        v1_d = v1_q;
        if (pop) begin
            e0_d = e1_q;
            v0_d = v1_q;
            v1_d = 1'b0;
        end
        if (push) begin
            if (!v0_d) begin
                e0_d = in_data;
                v0_d = 1'b1;
            end else begin
                e1_d = in_data;
                v1_d = 1'b1;
            end
        end
        if (flush) begin
            v0_d = 1'b0;
            v1_d = 1'b0;
        end
    end

    // register the buffer
    always_ff @(posedge clock) begin
        if (reset) begin
            v0_q <= 1'b0;
            v1_q <= 1'b0;
            e0_q <= '0;
            e1_q <= '0;
        end else begin
            v0_q <= v0_d;
            v1_q <= v1_d;
            e0_q <= e0_d;
            e1_q <= e1_d;
        end
    end
endmodule

// File: dio_port.sv
// Purpose: 32-channel digital port with edge recording and timed output
// Assumes: pins are asynchronous; every other input is on clock
// Notes:   one fifo serves either recording or timed output
`timescale 1ns/1ps
module dio_port #(
    parameter int DEPTH = dio_pkg::FIFO_DEPTH
) (
    input  wire logic                          clock,
    input  wire logic                          reset,
    input  wire logic [dio_pkg::CHANNELS-1:0]  pin_in,
    output logic      [dio_pkg::CHANNELS-1:0]  pin_out,
    output logic      [dio_pkg::CHANNELS-1:0]  pin_oe,
    input  wire logic [dio_pkg::GROUPS-1:0]    group_output,
    input  wire logic                          filter_enable,
    input  wire logic [dio_pkg::FILT_W-1:0]    filter_length,
    input  wire logic                          fifo_mode,
    input  wire logic                          fifo_enable,
    input  wire logic                          fifo_clear,
    input  wire logic                          wr_valid,
    output logic                               wr_ready,
    input  wire dio_pkg::dio_entry_type        wr_data,
    output logic                               rd_valid,
    input  wire logic                          rd_ready,
    output dio_pkg::dio_entry_type             rd_data,
    input  wire logic                          edge_clear,
    output logic      [dio_pkg::CHANNELS-1:0]  rise_flags,
    output logic      [dio_pkg::CHANNELS-1:0]  fall_flags,
    output logic      [dio_pkg::CHANNELS-1:0]  in_level,
    output logic                               fifo_full,
    output logic                               fifo_empty
);
    localparam int CH    = dio_pkg::CHANNELS;
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [PTR_W-1:0] PTR_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
    localparam logic [dio_pkg::DIV_W-1:0] DIV_LAST =
        dio_pkg::DIV_W'(dio_pkg::SAMPLE_DIV - 1);

    // refuse parameter values that the pointers and divider cannot serve
    if (DEPTH < 2 || dio_pkg::SAMPLE_DIV > 255 ||
        CH != dio_pkg::GROUPS * dio_pkg::GROUP_SIZE) begin : g_bad_param
        $error("dio_port: unsupported depth or sample divider");
    end

    // pin synchroniser, filter and edge state
    logic [CH-1:0]             sync1_q;
    logic [CH-1:0]             sync2_q;
    logic [CH-1:0]             filt_q;
    logic [CH-1:0]             filt_d;
    logic [dio_pkg::FILT_W-1:0] fcnt_q [CH];
    logic [dio_pkg::FILT_W-1:0] fcnt_d [CH];
    logic [CH-1:0]             prev_q;
    logic [CH-1:0]             prev_d;
    logic [CH-1:0]             rise_q;
    logic [CH-1:0]             rise_d;
    logic [CH-1:0]             fall_q;
    logic [CH-1:0]             fall_d;
    // sample timing
    logic [dio_pkg::DIV_W-1:0] div_q;
    logic [dio_pkg::DIV_W-1:0] div_d;
    logic [dio_pkg::STAMP_W-1:0] stamp_q;
    logic [dio_pkg::STAMP_W-1:0] stamp_d;
    logic                      strobe;
    // fifo and output state
    dio_pkg::dio_entry_type    mem_q [DEPTH];
    logic [PTR_W-1:0]          wp_q;
    logic [PTR_W-1:0]          wp_d;
    logic [PTR_W-1:0]          rp_q;
    logic [PTR_W-1:0]          rp_d;
    logic [CNT_W-1:0]          cnt_q;
    logic [CNT_W-1:0]          cnt_d;
    logic                      push;
    logic                      pop;
    dio_pkg::dio_entry_type    push_data;
    dio_pkg::dio_entry_type    head;
    logic                      rec_push;
    logic                      host_push;
    logic                      out_pop;
    logic                      buf_push;
    logic                      buf_ready;
    logic [CH-1:0]             pat_q;
    logic [CH-1:0]             pat_d;
    logic [CH-1:0]             oe_q;
    logic [CH-1:0]             oe_d;
    logic                      wr_ready_q;
    logic                      wr_ready_d;
    logic                      full_q;
    logic                      full_d;
    logic                      empty_q;
    logic                      empty_d;

    function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
        ptr_next = (p == PTR_LAST) ? PTR_ZERO : p + 1'b1;
    endfunction

    // true while the stamp counter has not yet reached the given time
    function automatic logic stamp_before(
        input logic [dio_pkg::STAMP_W-1:0] cur,
        input logic [dio_pkg::STAMP_W-1:0] t);
        logic [dio_pkg::STAMP_W-1:0] diff;
        diff = cur - t;
        stamp_before = diff[dio_pkg::STAMP_W-1];
    endfunction

    assign strobe = (div_q == DIV_LAST);
    assign head   = mem_q[rp_q];

    // two flip-flops ahead of any logic on the pins
    always_ff @(posedge clock) begin
        if (reset) begin
            sync1_q <= dio_pkg::CH_LOW;
            sync2_q <= dio_pkg::CH_LOW;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end

    // one spike filter per channel, all sharing enable and length
    for (genvar c = 0; c < CH; c++) begin : g_filt
        always_comb begin
            filt_d[c] = filt_q[c];
            fcnt_d[c] = fcnt_q[c];
            if (!filter_enable) begin
                filt_d[c] = sync2_q[c];
                fcnt_d[c] = dio_pkg::FILT_ZERO;
            end else if (strobe) begin
                if (sync2_q[c] == filt_q[c]) begin
                    fcnt_d[c] = dio_pkg::FILT_ZERO;
                end else if (fcnt_q[c] + dio_pkg::FILT_ONE >= filter_length)
                begin
                    filt_d[c] = sync2_q[c];
                    fcnt_d[c] = dio_pkg::FILT_ZERO;
                end else begin
                    fcnt_d[c] = fcnt_q[c] + dio_pkg::FILT_ONE;
                end
            end
        end
        always_ff @(posedge clock) begin
            if (reset) begin
                fcnt_q[c] <= dio_pkg::FILT_ZERO;
            end else begin
                fcnt_q[c] <= fcnt_d[c];
            end
        end
    end

    // sample divider, stamp counter, edge flags with set over clear
    always_comb begin
        div_d   = strobe ? dio_pkg::DIV_ZERO : div_q + dio_pkg::DIV_ONE;
        stamp_d = strobe ? stamp_q + 1'b1 : stamp_q;
        prev_d  = strobe ? filt_q : prev_q;
        rise_d  = (edge_clear ? dio_pkg::CH_LOW : rise_q)
                | (strobe ? (filt_q & ~prev_q) : dio_pkg::CH_LOW);
        fall_d  = (edge_clear ? dio_pkg::CH_LOW : fall_q)
                | (strobe ? (~filt_q & prev_q) : dio_pkg::CH_LOW);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            filt_q  <= dio_pkg::CH_LOW;
            div_q   <= dio_pkg::DIV_ZERO;
            stamp_q <= dio_pkg::STAMP_ZERO;
            prev_q  <= dio_pkg::CH_LOW;
            rise_q  <= dio_pkg::CH_LOW;
            fall_q  <= dio_pkg::CH_LOW;
        end else begin
            filt_q  <= filt_d;
            div_q   <= div_d;
            stamp_q <= stamp_d;
            prev_q  <= prev_d;
            rise_q  <= rise_d;
            fall_q  <= fall_d;
        end
    end

    // fifo pointers; one use at a time selected by fifo_mode
    always_comb begin
        rec_push  = fifo_enable && fifo_mode == dio_pkg::MODE_RECORD
                 && strobe && (filt_q != prev_q)
                 && cnt_q != CNT_FULL;
        host_push = fifo_mode == dio_pkg::MODE_OUTPUT
                 && wr_valid && wr_ready_q;
        buf_push  = fifo_mode == dio_pkg::MODE_RECORD
                 && cnt_q != CNT_ZERO && !fifo_clear;
        out_pop   = fifo_enable && fifo_mode == dio_pkg::MODE_OUTPUT
                 && cnt_q != CNT_ZERO
                 && !stamp_before(stamp_q, head.stamp);
        push      = rec_push || host_push;
        pop       = (buf_push && buf_ready) || out_pop;
        push_data = rec_push
                  ? dio_pkg::dio_entry_type'{pattern: filt_q, stamp: stamp_q}
                  : wr_data;
        wp_d = push ? ptr_next(wp_q) : wp_q;
        rp_d = pop ? ptr_next(rp_q) : rp_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + CNT_ONE;
        end else if (pop && !push) begin
            cnt_d = cnt_q - CNT_ONE;
        end
        if (fifo_clear) begin
            wp_d  = PTR_ZERO;
            rp_d  = PTR_ZERO;
            cnt_d = CNT_ZERO;
        end
        // host writes only in output mode and while there is room
        wr_ready_d = fifo_mode == dio_pkg::MODE_OUTPUT
                  && cnt_d != CNT_FULL && !fifo_clear;
        full_d     = cnt_d == CNT_FULL;
        empty_d    = cnt_d == CNT_ZERO;
        pat_d = out_pop ? head.pattern : pat_q;
        for (int g = 0; g < dio_pkg::GROUPS; g++) begin
            oe_d[g*dio_pkg::GROUP_SIZE +: dio_pkg::GROUP_SIZE] =
                {dio_pkg::GROUP_SIZE{group_output[g]}};
        end
    end

    always_ff @(posedge clock) begin
        if (push && !fifo_clear) begin
            mem_q[wp_q] <= push_data;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wp_q       <= PTR_ZERO;
            rp_q       <= PTR_ZERO;
            cnt_q      <= CNT_ZERO;
            pat_q      <= dio_pkg::CH_LOW;
            oe_q       <= dio_pkg::CH_LOW;
            wr_ready_q <= 1'b0;
            full_q     <= 1'b0;
            empty_q    <= 1'b1;
        end else begin
            wp_q       <= wp_d;
            rp_q       <= rp_d;
            cnt_q      <= cnt_d;
            pat_q      <= pat_d;
            oe_q       <= oe_d;
            wr_ready_q <= wr_ready_d;
            full_q     <= full_d;
            empty_q    <= empty_d;
        end
    end

    // read side buffer so a stalled reader loses no entry
    dio_skid dio_skid_inst (
        .clock     (clock),
        .reset     (reset),
        .flush     (fifo_clear),
        .in_valid  (buf_push),
        .in_ready  (buf_ready),
        .in_data   (head),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    assign pin_out    = pat_q;
    assign pin_oe     = oe_q;
    assign wr_ready   = wr_ready_q;
    assign rise_flags = rise_q;
    assign fall_flags = fall_q;
    assign in_level   = filt_q;
    assign fifo_full  = full_q;
    assign fifo_empty = empty_q;
endmodule

// File: dio_port_props.sv
// Purpose: concurrent checks on the ports of the edge monitor port
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into every dio_port instance
`timescale 1ns/1ps
module dio_port_props #(
    parameter int DEPTH = 4
) (
    input wire logic                   clock,
    input wire logic                   reset,
    input wire logic [31:0]            pin_out,
    input wire logic [31:0]            pin_oe,
    input wire logic [3:0]             group_output,
    input wire logic                   fifo_mode,
    input wire logic                   fifo_enable,
    input wire logic                   fifo_clear,
    input wire logic                   wr_valid,
    input wire logic                   wr_ready,
    input wire logic                   rd_valid,
    input wire logic                   rd_ready,
    input wire dio_pkg::dio_entry_type rd_data,
    input wire logic                   edge_clear,
    input wire logic [31:0]            rise_flags,
    input wire logic                   fifo_full,
    input wire logic                   fifo_empty
);
    logic [31:0] oe_exp;
    // one direction bit spread over eight channels
    always_comb begin
        for (int g = 0; g < 4; g++) begin
            oe_exp[g*8 +: 8] = {8{group_output[g]}};
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    chk_oe_group: assert property (
        pin_oe == ($past(reset) ? 32'h0000_0000 : $past(oe_exp)))
        else $error("pin_oe does not follow group_output");
    chk_reset_inputs: assert property (
        $past(reset) |-> pin_oe == 32'h0000_0000)
        else $error("a channel drives after reset");
    chk_flag_sticky: assert property (
        !edge_clear |=>
        (rise_flags & $past(rise_flags)) == $past(rise_flags))
        else $error("rise flag dropped without clear");
    chk_rd_hold: assert property (
        rd_valid && !rd_ready && !fifo_clear |=> rd_valid && $stable(rd_data))
        else $error("read entry not held");
    chk_wr_refuse: assert property (
        fifo_mode == dio_pkg::MODE_RECORD |=> !wr_ready)
        else $error("write accepted in record mode");
    chk_wr_fill: assert property (
        fifo_mode && !fifo_enable && !fifo_clear && wr_valid && wr_ready
        |=> !fifo_empty)
        else $error("empty after a write");
    chk_clear_empty: assert property (
        fifo_clear && !fifo_enable |-> ##[1:2] (fifo_empty && !rd_valid))
        else $error("clear left entries");
    chk_pins_held: assert property (
        !fifo_enable ##1 !fifo_enable |=> $stable(pin_out))
        else $error("pin_out moved while disabled");
    cover property (rd_valid && rd_ready);
    cover property (wr_valid && wr_ready);
    cover property (fifo_full);
    cover property (fifo_enable && $changed(pin_out));
endmodule
bind dio_port dio_port_props #(.DEPTH(DEPTH)) dio_port_props_inst (
    .clock, .reset, .pin_out, .pin_oe, .group_output, .fifo_mode,
    .fifo_enable, .fifo_clear, .wr_valid, .wr_ready, .rd_valid, .rd_ready,
    .rd_data, .edge_clear, .rise_flags, .fifo_full, .fifo_empty
);

// File: dio_pins.sv
// Purpose: outside equipment wired to the 32 channel pins
// Assumes: bench sets the level that outside drivers apply
// Notes:   a driven channel reads back its own level
`timescale 1ns/1ps
module dio_pins (
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    input  wire logic [31:0] ext_level,
    output logic      [31:0] pin_in
);
    // the port wins where it drives, the outside elsewhere
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// File: dio_port_test.sv
// Purpose: directed test of recording, filter and timed output
// Assumes: inputs change at the falling edge
// Notes:   small fifo depth so that it fills quickly
`timescale 1ns/1ps
module dio_port_test;
    localparam int DEPTH = 4;
    logic        clock = 1'b0, reset = 1'b1;
    logic [31:0] pin_in, pin_out, pin_oe, rise_flags, fall_flags, in_level;
    logic [31:0] ext_level = 32'h0000_0000, cyc = 32'h0000_0000;
    logic [3:0]  group_output = 4'h0;
    logic [7:0]  filter_length = 8'h00;
    logic        filter_enable = 1'b0, fifo_mode = 1'b0, fifo_enable = 1'b0;
    logic        fifo_clear = 1'b0, wr_valid = 1'b0, rd_ready = 1'b0;
    logic        edge_clear = 1'b0, wr_ready, rd_valid, fifo_full, fifo_empty;
    dio_pkg::dio_entry_type wr_data = '0, rd_data;
    int          errors = 0, check_count = 0;
    dio_port #(.DEPTH(DEPTH)) dio_port_inst (.clock, .reset, .pin_in,
        .pin_out, .pin_oe, .group_output, .filter_enable, .filter_length,
        .fifo_mode, .fifo_enable, .fifo_clear, .wr_valid, .wr_ready,
        .wr_data, .rd_valid, .rd_ready, .rd_data, .edge_clear, .rise_flags,
        .fall_flags, .in_level, .fifo_full, .fifo_empty);
    dio_pins dio_pins_inst (.pin_out, .pin_oe, .ext_level, .pin_in);
    // clock and a cycle count that tracks the stamp counter
    always #20 clock = ~clock;
    always @(posedge clock) cyc <= reset ? 32'h0000_0000 : cyc + 1;
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wait_hi(input bit on_read);
        int n;
        n = 0;
        while ((on_read ? rd_valid : wr_ready) !== 1'b1) begin
            n++;
            if (n > 50) begin
                errors++;
                $display("BAD %0t handshake never came", $time);
                close_out();
            end
            tick(1);
        end
    endtask
    task automatic wr_put(input logic [31:0] pat, input logic [31:0] t);
        wr_valid = 1'b1;
        wr_data = '{pattern: pat, stamp: t};
        wait_hi(1'b0);
        tick(1);
        wr_valid = 1'b0;
        tick(1);
    endtask
    task automatic rd_get(output dio_pkg::dio_entry_type e);
        wait_hi(1'b1);
        e = rd_data;
        rd_ready = 1'b1;
        tick(1);
        rd_ready = 1'b0;
        tick(1);
    endtask
    task automatic clear_fifo;
        fifo_clear = 1'b1;
        tick(1);
        fifo_clear = 1'b0;
        tick(2);
    endtask
    // main sequence
    initial begin
        dio_pkg::dio_entry_type e, f;
        logic [31:0] t;
        int n;
        tick(10);
        reset = 1'b0;
        tick(3);
        chk(pin_oe, 32'h0000_0000);
        chk(32'(fifo_empty), 32'h0000_0001);
        chk(32'(wr_ready), 32'h0000_0000);
        for (int g = 0; g < 4; g++) begin
            group_output = 4'(1 << g);
            tick(2);
            chk(pin_oe, 32'h0000_00FF << (8 * g));
        end
        group_output = 4'h0;
        fifo_enable = 1'b1;
        tick(5);
        ext_level = 32'h8000_0001;
        tick(5);
        ext_level = 32'h0000_0000;
        tick(1);
        ext_level = 32'h0000_0010;
        tick(1);
        ext_level = 32'h0000_0000;
        rd_get(e);
        chk(e.pattern, 32'h8000_0001);
        rd_get(f);
        chk(f.stamp - e.stamp, 32'h0000_0005);
        rd_get(e);
        chk(e.pattern, 32'h0000_0010);
        chk(e.stamp - f.stamp, 32'h0000_0001);
        rd_get(f);
        chk(rise_flags, 32'h8000_0011);
        chk(fall_flags, 32'h8000_0011);
        edge_clear = 1'b1;
        tick(1);
        edge_clear = 1'b0;
        tick(1);
        chk(rise_flags | fall_flags, 32'h0000_0000);
        for (int i = 1; i <= 8; i++) begin
            ext_level = 32'(i);
            tick(3);
        end
        chk(32'(fifo_full), 32'h0000_0001);
        n = 0;
        while (rd_valid === 1'b1 && n < 10) begin
            rd_get(e);
            n++;
            chk(e.pattern, 32'(n));
        end
        chk(32'(n >= DEPTH && n <= DEPTH + 2), 32'h0000_0001);
        filter_length = 8'h04;
        filter_enable = 1'b1;
        clear_fifo();
        ext_level = 32'h0000_00FF;
        tick(2);
        ext_level = 32'h0000_0008;
        tick(10);
        chk(32'(rd_valid), 32'h0000_0000);
        ext_level = 32'h0000_00FF;
        tick(10);
        rd_get(e);
        chk(e.pattern, 32'h0000_00FF);
        filter_enable = 1'b0;
        fifo_enable = 1'b0;
        fifo_mode = dio_pkg::MODE_OUTPUT;
        group_output = 4'hF;
        clear_fifo();
        t = cyc;
        wr_put(32'hA5A5_0F0F, t + 32'h0000_0028);
        wr_put(32'h0102_0304, t + 32'h0000_003C);
        chk(32'(fifo_empty), 32'h0000_0000);
        fifo_enable = 1'b1;
        while (cyc < t + 32'h0000_0024) tick(1);
        chk(pin_out, 32'h0000_0000);
        while (cyc < t + 32'h0000_002C) tick(1);
        chk(pin_out, 32'hA5A5_0F0F);
        while (cyc < t + 32'h0000_0040) tick(1);
        chk(pin_out, 32'h0102_0304);
        chk(in_level, 32'h0102_0304);
        chk(32'(fifo_empty), 32'h0000_0001);
        wr_put(32'h0000_FFFF, t);
        tick(4);
        chk(pin_out, 32'h0000_FFFF);
        close_out();
    end
endmodule
